/* File: rtl/rhm_pkg.sv */
// Package of constants for the running-hour meter.
package rhm_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SETPOINT_OFS = 8'h04;
  localparam logic [7:0] WORD0_OFS = 8'h08;
  localparam logic [7:0] WORD1_OFS = 8'h0C;
  localparam logic [7:0] WORD2_OFS = 8'h10;
  localparam logic [7:0] WORD3_OFS = 8'h14;
  localparam logic [7:0] ERRCODE_OFS = 8'h18;
  localparam logic [7:0] BASE_OFS = 8'h1C;
  localparam logic [7:0] INT_STATUS_OFS = 8'h20;
  localparam logic [7:0] INT_MASK_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WIDE_BIT = 1;
  localparam int EV_OUTPUT_BIT = 0;
  localparam int EV_ERROR_BIT = 1;
  localparam int EV_SAT_BIT = 2;
  localparam int ST_OUTPUT_BIT = 0;
  localparam int ST_ERROR_BIT = 1;
  localparam int ST_SAT_BIT = 2;
  localparam int ST_RUN_BIT = 3;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] SETPOINT_RST = 32'h0000_0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [15:0] ERRCODE_RST = 16'h0000;
  localparam logic [2:0] EVENT_RST = 3'h0;

  // Limits and codes
  localparam logic [15:0] NARROW_HOUR_MAX = 16'h7FFF;
  localparam logic [31:0] WIDE_HOUR_MAX = 32'h7FFF_FFFF;
  localparam logic [15:0] SEC_MAX = 16'h0E0F;
  localparam logic [15:0] RANGE_ERR_CODE = 16'h2003;
  localparam logic [15:0] LAST_WORD_INDEX = 16'hFFFF;

  // Timing
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
endpackage

/* File: rtl/rhm_top.sv */
// Running-hour meter with APB register access and a level interrupt.
`timescale 1ns/1ns
// Summary of operation
// - Narrow mode keeps hours 0..32,767 in word 0 and seconds 0..3,599 in word 1.
// - The word after the count words is device-owned and a write to it while running is an error.
// - Narrow mode stops at 32,767 h 3,599 s and resumes as soon as word 0 or word 1 no longer holds that value.
// - Wide mode keeps hours in words 0 and 1 (upper second), seconds in word 2, word 3 reserved.
// - Wide mode stops at 2,147,483,647 h 3,599 s and resumes as soon as words 0..2 no longer hold that value.
// - The output asserts once accumulated hours reach the setpoint and stays low below it.
// - Counting continues after the output has asserted.
// - Time accumulates only while enable is on, and counting starts when enable turns on.
// - A setpoint of zero or below skips the update and holds the output.
// - A negative hour value holds the output unchanged.
// - Narrow mode with the reserved word out of range skips, flags error and stores 16#2003.
// - Wide mode with the reserved word out of range skips, flags error and stores 16#2003.
module rhm_top #(
  parameter int TICK_CYCLES = rhm_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic threshold_output,
  output logic operation_error_flag,
  output logic irq
);

  logic [1:0] ctrl_r;
  logic [31:0] setpoint_r;
  logic [15:0] elapsed_count_words [4];
  logic [15:0] error_code_word;
  logic [15:0] base_r;
  logic [2:0] int_status_r;
  logic [2:0] int_mask_r;
  logic run_d_r;
  logic [31:0] tick_cnt_r;
  logic out_r;
  logic [31:0] prdata_r;

  logic wr_acc;
  logic rd_acc;
  logic [7:0] ofs;
  logic mapped;
  logic run;
  logic wide;
  logic run_rise;
  logic tick;
  logic [31:0] hours;
  logic [15:0] secs;
  logic sp_bad;
  logic hours_neg;
  logic range_bad;
  logic rsv_tamper;
  logic err_now;
  logic saturated;
  logic count_step;
  logic out_nxt;
  logic [2:0] ev_set;
  logic [15:0] rsv_word;

  function automatic logic reg_mapped(input logic [7:0] a);
    unique case (a)
      rhm_pkg::CTRL_OFS, rhm_pkg::SETPOINT_OFS, rhm_pkg::WORD0_OFS, rhm_pkg::WORD1_OFS,
      rhm_pkg::WORD2_OFS, rhm_pkg::WORD3_OFS, rhm_pkg::ERRCODE_OFS, rhm_pkg::BASE_OFS,
      rhm_pkg::INT_STATUS_OFS, rhm_pkg::INT_MASK_OFS, rhm_pkg::STATUS_OFS: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] word_ofs(input int idx);
    word_ofs = 8'(rhm_pkg::WORD0_OFS + 8'(4 * idx));
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign ofs = paddr[7:0];
  assign mapped = reg_mapped(ofs) && (paddr[31:8] == 24'h00_0000);
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_acc = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign run = ctrl_r[rhm_pkg::CTRL_RUN_BIT];
  assign wide = ctrl_r[rhm_pkg::CTRL_WIDE_BIT];
  assign run_rise = run && !run_d_r;
  assign tick = run && (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // Word layout depends on mode
  assign hours = wide ? {elapsed_count_words[1], elapsed_count_words[0]}
                      : {16'h0000, elapsed_count_words[0]};
  assign secs = wide ? elapsed_count_words[2] : elapsed_count_words[1];
  assign sp_bad = wide ? ($signed(setpoint_r) <= 0)
                       : ($signed(setpoint_r[15:0]) <= 0);
  assign hours_neg = wide ? elapsed_count_words[1][15] : elapsed_count_words[0][15];
  // Reserved word index must stay inside the word space
  assign range_bad = wide ? (base_r > 16'(rhm_pkg::LAST_WORD_INDEX - 16'h0003))
                          : (base_r > 16'(rhm_pkg::LAST_WORD_INDEX - 16'h0002));
  assign rsv_tamper = run && wr_acc &&
                      (ofs == (wide ? rhm_pkg::WORD3_OFS : rhm_pkg::WORD2_OFS));
  assign err_now = run && (range_bad || rsv_tamper);
  // Device-owned word moves with the mode, so checks follow it through this view
  assign rsv_word = wide ? elapsed_count_words[3] : elapsed_count_words[2];
  assign saturated = wide ? (hours == rhm_pkg::WIDE_HOUR_MAX && secs == rhm_pkg::SEC_MAX)
                          : (hours[15:0] == rhm_pkg::NARROW_HOUR_MAX
                             && secs == rhm_pkg::SEC_MAX);
  // Error holds the meter until software clears the flag
  assign count_step = tick && !sp_bad && !hours_neg && !err_now && !saturated
                      && !int_status_r[rhm_pkg::EV_ERROR_BIT];

  always_comb
  begin
    out_nxt = out_r;
    if (run && !sp_bad && !hours_neg && !err_now && !int_status_r[rhm_pkg::EV_ERROR_BIT])
    begin
      if (wide)
        out_nxt = hours >= setpoint_r;
      else
        out_nxt = hours[15:0] >= setpoint_r[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= rhm_pkg::CTRL_RST;
      setpoint_r <= rhm_pkg::SETPOINT_RST;
      base_r <= rhm_pkg::BASE_RST;
      int_mask_r <= rhm_pkg::EVENT_RST;
    end
    else if (wr_acc)
    begin
      unique case (ofs)
        rhm_pkg::CTRL_OFS: ctrl_r <= pwdata[1:0];
        rhm_pkg::SETPOINT_OFS: setpoint_r <= pwdata;
        rhm_pkg::BASE_OFS: base_r <= pwdata[15:0];
        rhm_pkg::INT_MASK_OFS: int_mask_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Prescaler restarts on every enable rise so the first second is whole
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_d_r <= 1'b0;
      tick_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      run_d_r <= run;
      if (!run || run_rise || tick)
        tick_cnt_r <= 32'h0000_0000;
      else
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Count words: a software write in the same cycle wins over a hardware step
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_word
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
          elapsed_count_words[i] <= rhm_pkg::WORD_RST;
        else if (wr_acc && ofs == word_ofs(i) && !(rsv_tamper && ofs == word_ofs(i)))
          elapsed_count_words[i] <= pwdata[15:0];
        else if (run_rise && i == (wide ? 3 : 2))
          elapsed_count_words[i] <= rhm_pkg::WORD_RST;
        else if (count_step)
        begin
          if (i == (wide ? 2 : 1))
            elapsed_count_words[i] <= (secs == rhm_pkg::SEC_MAX) ? 16'h0000
                                      : 16'(secs + 16'h0001);
          else if (secs == rhm_pkg::SEC_MAX)
          begin
            if (i == 0)
              elapsed_count_words[i] <= 16'(hours[15:0] + 16'h0001);
            else if (i == 1 && wide && hours[15:0] == 16'hFFFF)
              elapsed_count_words[i] <= 16'(hours[31:16] + 16'h0001);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      error_code_word <= rhm_pkg::ERRCODE_RST;
    else if (err_now)
      error_code_word <= rhm_pkg::RANGE_ERR_CODE;
    else if (wr_acc && ofs == rhm_pkg::ERRCODE_OFS)
      error_code_word <= pwdata[15:0];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      out_r <= 1'b0;
    else
      out_r <= out_nxt;
  end

  // Sticky events: set wins over a write-one clear in the same cycle
  assign ev_set[rhm_pkg::EV_OUTPUT_BIT] = out_nxt && !out_r;
  assign ev_set[rhm_pkg::EV_ERROR_BIT] = err_now;
  assign ev_set[rhm_pkg::EV_SAT_BIT] = run && saturated;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      int_status_r <= rhm_pkg::EVENT_RST;
    else if (wr_acc && ofs == rhm_pkg::INT_STATUS_OFS)
      int_status_r <= (int_status_r & ~pwdata[2:0]) | ev_set;
    else
      int_status_r <= int_status_r | ev_set;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prdata_r <= 32'h0000_0000;
    else if (rd_acc)
    begin
      unique case (ofs)
        rhm_pkg::CTRL_OFS: prdata_r <= {30'h0000_0000, ctrl_r};
        rhm_pkg::SETPOINT_OFS: prdata_r <= setpoint_r;
        rhm_pkg::WORD0_OFS: prdata_r <= {16'h0000, elapsed_count_words[0]};
        rhm_pkg::WORD1_OFS: prdata_r <= {16'h0000, elapsed_count_words[1]};
        rhm_pkg::WORD2_OFS: prdata_r <= {16'h0000, elapsed_count_words[2]};
        rhm_pkg::WORD3_OFS: prdata_r <= {16'h0000, elapsed_count_words[3]};
        rhm_pkg::ERRCODE_OFS: prdata_r <= {16'h0000, error_code_word};
        rhm_pkg::BASE_OFS: prdata_r <= {16'h0000, base_r};
        rhm_pkg::INT_STATUS_OFS: prdata_r <= {29'h0000_0000, int_status_r};
        rhm_pkg::INT_MASK_OFS: prdata_r <= {29'h0000_0000, int_mask_r};
        rhm_pkg::STATUS_OFS: prdata_r <= {28'h000_0000, run, saturated,
                                         int_status_r[rhm_pkg::EV_ERROR_BIT], out_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign threshold_output = out_r;
  assign operation_error_flag = int_status_r[rhm_pkg::EV_ERROR_BIT];
  assign irq = |(int_status_r & int_mask_r);

  // Checks
  sequence s_tamper;
    run && wr_acc && ofs == (wide ? rhm_pkg::WORD3_OFS : rhm_pkg::WORD2_OFS);
  endsequence

  sequence s_flagged;
    operation_error_flag && error_code_word == rhm_pkg::RANGE_ERR_CODE;
  endsequence

  sequence s_frozen;
    $stable(hours) && $stable(secs);
  endsequence

  a_tamper_flags_error: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_tamper |=> s_flagged)
    else $error("reserved word write did not raise error");

  a_range_error_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
    run && !wide && range_bad |=> s_flagged)
    else $error("narrow range error not reported");

  a_wide_range_error: assert property (@(posedge clk_sys) disable iff (!reset_n)
    run && wide && range_bad |=> s_flagged)
    else $error("wide range error not reported");

  a_sat_holds_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
    run && saturated && !wr_acc |=> $stable(hours) && $stable(secs))
    else $error("count moved while saturated");

  a_sec_wrap_hour: assert property (@(posedge clk_sys) disable iff (!reset_n)
    count_step && secs == rhm_pkg::SEC_MAX && !wr_acc
    |=> secs == 16'h0000 && hours == $past(hours) + 32'h0000_0001)
    else $error("seconds wrap did not bump hours");

  a_sec_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
    count_step && secs != rhm_pkg::SEC_MAX && !wr_acc |=> secs == $past(secs) + 16'h0001)
    else $error("seconds did not step on tick");

  a_idle_no_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !run && !wr_acc && !$past(run) |=> $stable(hours) && $stable(secs))
    else $error("count moved while disabled");

  a_bad_sp_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sp_bad && !wr_acc |=> threshold_output == $past(threshold_output))
    else $error("output changed with bad setpoint");

  a_neg_hours_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hours_neg && !wr_acc |=> threshold_output == $past(threshold_output))
    else $error("output changed with negative hours");

  a_output_reach: assert property (@(posedge clk_sys) disable iff (!reset_n)
    run && !wide && !sp_bad && !hours_neg && !err_now && !operation_error_flag
    |=> threshold_output == ($past(hours[15:0]) >= $past(setpoint_r[15:0])))
    else $error("output does not follow setpoint compare");

  a_count_after_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
    threshold_output && count_step && !wr_acc |=> !$stable(secs))
    else $error("count stopped after output asserted");

  a_rsv_write_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_tamper && !run_rise |=> $stable(rsv_word))
    else $error("reserved word took a write while running");

  a_err_blocks_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
    operation_error_flag && !wr_acc |=> s_frozen)
    else $error("count moved while error flag set");

  a_sat_event: assert property (@(posedge clk_sys) disable iff (!reset_n)
    run && saturated |=> int_status_r[rhm_pkg::EV_SAT_BIT])
    else $error("saturation did not set its status bit");

  a_wide_output: assert property (@(posedge clk_sys) disable iff (!reset_n)
    run && wide && !sp_bad && !hours_neg && !err_now && !operation_error_flag
    |=> threshold_output == ($past(hours) >= $past(setpoint_r)))
    else $error("wide output does not follow setpoint compare");

  a_sec_only_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !tick && !wr_acc |=> $stable(secs))
    else $error("seconds moved without a tick");

  // A rise of the output must reach the pin at once when its event is unmasked
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
    threshold_output && !$past(threshold_output) && int_mask_r[rhm_pkg::EV_OUTPUT_BIT] |-> irq)
    else $error("output rise did not raise interrupt");

endmodule

/* File: verif/test_running_hour_meter.sv */
// Self-checking bench for the running-hour meter over APB.
`timescale 1ns/1ns
module test_running_hour_meter;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic threshold_output;
  logic operation_error_flag;
  logic irq;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h27A920AF;
  logic [31:0] rd;
  logic [31:0] tmp;
  logic err;
  logic [15:0] h;
  logic [15:0] sp;

  // Short prescaler so an hour is 14,400 clocks
  rhm_top #(.TICK_CYCLES(4)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .threshold_output(threshold_output),
    .operation_error_flag(operation_error_flag), .irq(irq));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic exp_out(input logic [15:0] hr, input logic [15:0] set);
    return hr >= set;
  endfunction

  task automatic tally_and_finish;
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // One APB transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] ofs, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, ofs};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    apb(1'b1, ofs, d);
  endtask

  task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp);
    apb(1'b0, ofs, 32'h0);
    chk(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Stop, preset the count words and setpoint, then start with mode c
  task automatic load(input logic [1:0] c, input logic [15:0] w0, input logic [15:0] w1,
    input logic [15:0] w2, input logic [31:0] set);
    wr(rhm_pkg::CTRL_OFS, {30'h0, c & 2'h2});
    wr(rhm_pkg::WORD0_OFS, {16'h0, w0});
    wr(rhm_pkg::WORD1_OFS, {16'h0, w1});
    wr(rhm_pkg::WORD2_OFS, {16'h0, w2});
    wr(rhm_pkg::SETPOINT_OFS, set);
    wr(rhm_pkg::CTRL_OFS, {30'h0, c});
  endtask

  task automatic base_chk(input logic [15:0] b, input logic [1:0] c, input logic e);
    wr(rhm_pkg::CTRL_OFS, 32'h0);
    wr(rhm_pkg::BASE_OFS, {16'h0, b});
    wr(rhm_pkg::CTRL_OFS, {30'h0, c});
    idle(3);
    chb(operation_error_flag, e);
    if (e)
      rchk(rhm_pkg::ERRCODE_OFS, 32'h2003);
    wr(rhm_pkg::CTRL_OFS, 32'h0);
    wr(rhm_pkg::BASE_OFS, 32'h0);
    wr(rhm_pkg::INT_STATUS_OFS, 32'h7);
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rchk(rhm_pkg::SETPOINT_OFS, 32'h0);
    rchk(rhm_pkg::INT_STATUS_OFS, 32'h0);
    rchk(rhm_pkg::STATUS_OFS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    wr(rhm_pkg::INT_MASK_OFS, 32'h1);
    wr(rhm_pkg::WORD1_OFS, 32'h0E0B);
    idle(20);
    rchk(rhm_pkg::WORD1_OFS, 32'h0E0B);
    load(2'h1, 16'h0, 16'h0E0B, 16'h0, 32'h1);
    idle(4);
    chb(threshold_output, 1'b0);
    wait_out();
    rchk(rhm_pkg::WORD0_OFS, 32'h1);
    chb(irq, 1'b1);
    wr(rhm_pkg::INT_STATUS_OFS, 32'h1);
    chb(irq, 1'b0);
    idle(12);
    wr(rhm_pkg::CTRL_OFS, 32'h0);
    apb(1'b0, rhm_pkg::WORD1_OFS, 32'h0);
    tmp = rd;
    chb(tmp > 0 && tmp < 32, 1'b1);
    idle(20);
    rchk(rhm_pkg::WORD1_OFS, tmp);
    load(2'h1, 16'h7FFF, 16'h0E0E, 16'h0, 32'h1);
    idle(40);
    rchk(rhm_pkg::WORD0_OFS, 32'h7FFF);
    rchk(rhm_pkg::WORD1_OFS, 32'h0E0F);
    rchk(rhm_pkg::STATUS_OFS, 32'hD);
    rchk(rhm_pkg::INT_STATUS_OFS, 32'h4);
    wr(rhm_pkg::WORD0_OFS, 32'h0);
    wr(rhm_pkg::WORD1_OFS, 32'h0);
    idle(20);
    apb(1'b0, rhm_pkg::WORD1_OFS, 32'h0);
    chb(rd != 0, 1'b1);
    load(2'h1, 16'h5, 16'h0, 16'h0, 32'h8000);
    idle(20);
    chb(threshold_output, 1'b1);
    rchk(rhm_pkg::WORD1_OFS, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      h = (i == 0) ? 16'h5 : {8'h0, seed[7:0]};
      sp = (i == 0) ? 16'h5 : {8'h0, seed[15:8]} + 16'h1;
      load(2'h1, h, 16'h0, 16'h0, {16'h0, sp});
      idle(3);
      chb(threshold_output, exp_out(h, sp));
    end
    load(2'h1, 16'h0, 16'h0, 16'h0, 32'h5);
    idle(3);
    load(2'h1, 16'h8000, 16'h0, 16'h0, 32'h1);
    idle(20);
    chb(threshold_output, 1'b0);
    load(2'h1, 16'h0, 16'h0, 16'h0, 32'h1);
    wr(rhm_pkg::INT_STATUS_OFS, 32'h7);
    wr(rhm_pkg::WORD2_OFS, 32'h1234);
    idle(2);
    chb(operation_error_flag, 1'b1);
    chb(irq, 1'b0);
    rchk(rhm_pkg::ERRCODE_OFS, 32'h2003);
    apb(1'b0, rhm_pkg::WORD1_OFS, 32'h0);
    tmp = rd;
    idle(20);
    rchk(rhm_pkg::WORD1_OFS, tmp);
    wr(rhm_pkg::INT_MASK_OFS, 32'h3);
    chb(irq, 1'b1);
    wr(rhm_pkg::INT_STATUS_OFS, 32'h2);
    chb(operation_error_flag, 1'b0);
    base_chk(16'hFFFD, 2'h1, 1'b0);
    base_chk(16'hFFFE, 2'h1, 1'b1);
    base_chk(16'hFFFC, 2'h3, 1'b0);
    base_chk(16'hFFFD, 2'h3, 1'b1);
    load(2'h3, 16'hFFFF, 16'h0, 16'h0E0B, 32'h0001_0000);
    idle(4);
    chb(threshold_output, 1'b0);
    wait_out();
    rchk(rhm_pkg::WORD0_OFS, 32'h0);
    rchk(rhm_pkg::WORD1_OFS, 32'h1);
    load(2'h3, 16'hFFFF, 16'h7FFF, 16'h0E0E, 32'h1);
    idle(40);
    rchk(rhm_pkg::WORD1_OFS, 32'h7FFF);
    rchk(rhm_pkg::WORD2_OFS, 32'h0E0F);
    wr(rhm_pkg::WORD0_OFS, 32'h0);
    wr(rhm_pkg::WORD1_OFS, 32'h0);
    wr(rhm_pkg::WORD2_OFS, 32'h0);
    idle(20);
    apb(1'b0, rhm_pkg::WORD2_OFS, 32'h0);
    chb(rd != 0, 1'b1);
    tally_and_finish;
  end

  task automatic wait_out;
    int n;
    n = 0;
    while (threshold_output !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    chb(threshold_output, 1'b1);
  endtask
endmodule
